// file: rtl/suspend_wake_power_control.sv
// Purpose: suspend, wake-up, resume window, clock restart and port power protection
// Assumes: APB slave on pclk; all inputs synchronous to pclk
// Notes: main clocks are phase-accumulator outputs gated by state and reference presence
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "pwr_map.svh"

module suspend_wake_power_control #(
    parameter int OC_FILTER_CYCLES = `OC_FILTER_CYCLES // Overcurrent glitch filter length
) (
    input wire logic pclk, // System clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input pwr_pkg::apb_req_type apb_in, // APB request
    output pwr_pkg::apb_rsp_type apb_out, // APB answer
    input wire logic ref_clock_input, // 12 MHz reference, sampled
    input wire logic [2:0] port_connect, // Port attach level per port
    input wire logic suspend_wake_pin_in, // Wake pin level
    output logic suspend_wake_pin_out, // Wake pin drive value
    output logic suspend_wake_pin_oe, // Wake pin drive enable
    input wire logic [2:0] port_overcurrent_n, // Digital overcurrent, active low
    input wire logic [2:0] oc_analog_trip, // Analog trip per port
    output logic [2:0] port_power_switch_n, // Port power switch, active low
    output logic [2:0] main_clk_out, // 30, 48, 60 MHz clocks
    output logic slow_free_clock, // Slow free-running clock
    output logic [15:0] block_disable, // Internal block disables
    output logic clocks_ready_irq // Clock-ready interrupt level
);
    localparam logic [2:0][15:0] PHASE_INC = {16'(`PHASE_INC(`CLK60_KHZ)),
        16'(`PHASE_INC(`CLK48_KHZ)), 16'(`PHASE_INC(`CLK30_KHZ))};

    pwr_pkg::pwr_regs_type r;
    pwr_pkg::pwr_regs_type next_r;
    logic slow_tick;
    logic ref_rise;
    logic ref_ok;
    logic wake_event;
    logic setup;
    logic wr;
    logic sus_req;
    logic ready_set;
    logic running;
    logic trip;
    logic [11:0] a;

    // Slow clock stays alive through suspend
    slow_clock_gen u_slow (
        .pclk(pclk),
        .presetn(presetn),
        .slow_tick(slow_tick),
        .slow_clk(slow_free_clock)
    );

    // Address decode, used for the slave error answer
    function automatic logic hit(input logic [11:0] adr);
        hit = (adr == `HOST_CMD_OFF) || (adr == `HW_CFG_OFF) || (adr == `INTR_OFF) ||
              (adr == `PD_CTRL_OFF) || (adr == `STATUS_OFF) || (adr == `PORT_PWR_OFF);
    endfunction

    // Read multiplexer
    function automatic logic [31:0] rd(input pwr_pkg::pwr_regs_type s, input logic [11:0] adr);
        rd = 32'h0000_0000;
        case (adr)
            `HOST_CMD_OFF: rd[`RUN_STOP_BIT] = s.run_stop;
            `HW_CFG_OFF: rd = s.hw_cfg;
            `INTR_OFF: rd[`CLK_READY_BIT] = s.ready_flag;
            `PD_CTRL_OFF: rd = s.pd_ctrl;
            `STATUS_OFF: rd[8:0] = {ref_ok, ~s.psw_n, s.oc_latch, s.st};
            `PORT_PWR_OFF: rd[2:0] = s.port_en;
            default: rd = 32'h0000_0000;
        endcase
    endfunction

    // Next-state logic
    always_comb begin
        next_r = r;
        a = apb_in.paddr[11:0];
        setup = apb_in.psel && !apb_in.penable;
        wr = apb_in.psel && apb_in.penable && r.rsp.pready && apb_in.pwrite;
        sus_req = 1'b0;
        ready_set = 1'b0;

        // Reference supervision: edges must keep coming
        ref_rise = ref_clock_input && !r.ref_prev;
        next_r.ref_prev = ref_clock_input;
        if (ref_rise) begin
            next_r.ref_gap = 6'h00;
        end else if (r.ref_gap != `REF_GAP_MAX) begin
            next_r.ref_gap = r.ref_gap + 6'h01;
        end
        ref_ok = (r.ref_gap != `REF_GAP_MAX);

        // APB slave: answer ready in the access phase
        next_r.rsp.pready = setup;
        next_r.rsp.pslverr = setup && !hit(a);
        next_r.rsp.prdata = setup ? rd(r, a) : 32'h0000_0000;
        if (wr) begin
            case (a)
                `HOST_CMD_OFF: begin
                    next_r.run_stop = apb_in.pwdata[`RUN_STOP_BIT];
                    sus_req = apb_in.pwdata[`SUSPEND_REQ_BIT];
                end
                `HW_CFG_OFF: next_r.hw_cfg = apb_in.pwdata;
                `PD_CTRL_OFF: next_r.pd_ctrl = apb_in.pwdata;
                `PORT_PWR_OFF: begin
                    next_r.port_en = apb_in.pwdata[2:0];
                    next_r.oc_latch = r.oc_latch & ~apb_in.pwdata[2:0];
                end
                default: ;
            endcase
        end

        // Wake sources, sampled every cycle, acted on only in suspend
        next_r.conn_prev = port_connect;
        wake_event = (|(port_connect ^ r.conn_prev)) || apb_in.psel || !suspend_wake_pin_in;

        // Window counts slow ticks
        if ((r.st == pwr_pkg::PWR_WAKING || r.st == pwr_pkg::PWR_RESUME) && slow_tick && r.win_cnt != 16'h0000) begin
            next_r.win_cnt = r.win_cnt - 16'h0001;
        end

        // Power state machine
        case (r.st)
            pwr_pkg::PWR_SUSPEND: begin
                next_r.lock_cnt = 7'h00;
                if (wake_event) begin
                    next_r.st = pwr_pkg::PWR_WAKING;
                    next_r.win_cnt = r.pd_ctrl[31:`CLKOFF_LSB];
                end
            end
            pwr_pkg::PWR_WAKING: begin
                if (ref_rise) begin
                    next_r.lock_cnt = r.lock_cnt + 7'h01;
                end
                if (r.lock_cnt == `LOCK_REF_EDGES) begin
                    ready_set = 1'b1;
                    next_r.st = pwr_pkg::PWR_RESUME;
                end else if (r.win_cnt == 16'h0000) begin
                    next_r.st = pwr_pkg::PWR_SUSPEND;
                end
            end
            pwr_pkg::PWR_RESUME: begin
                if (r.run_stop) begin
                    next_r.st = pwr_pkg::PWR_RUN;
                end else if (r.win_cnt == 16'h0000) begin
                    next_r.st = pwr_pkg::PWR_SUSPEND;
                end
            end
            pwr_pkg::PWR_RUN: begin
                if (sus_req && !next_r.run_stop) begin
                    next_r.st = pwr_pkg::PWR_SUSPEND;
                end
            end
            default: next_r.st = pwr_pkg::PWR_SUSPEND;
        endcase

        // Clock-ready flag: write 1 clears, a new set wins
        if (wr && a == `INTR_OFF && apb_in.pwdata[`CLK_READY_BIT]) begin
            next_r.ready_flag = 1'b0;
        end
        if (ready_set) begin
            next_r.ready_flag = 1'b1;
        end
        next_r.irq = next_r.ready_flag;

        // Main clocks from the reference-locked accumulators
        running = ref_ok && (next_r.st == pwr_pkg::PWR_RESUME || next_r.st == pwr_pkg::PWR_RUN);
        for (int i = 0; i < 3; i++) begin
            next_r.acc[i] = running ? r.acc[i] + PHASE_INC[i] : 16'h0000;
            next_r.clk_out[i] = next_r.acc[i][15];
        end

        // Overcurrent per port, analog or digital
        for (int i = 0; i < 3; i++) begin
            trip = 1'b0;
            if (r.hw_cfg[`OC_DIGITAL_BIT]) begin
                if (port_overcurrent_n[i]) begin
                    next_r.oc_cnt[i] = 20'h00000;
                end else if (r.oc_cnt[i] >= 20'(OC_FILTER_CYCLES - 1)) begin
                    trip = 1'b1;
                end else begin
                    next_r.oc_cnt[i] = r.oc_cnt[i] + 20'h00001;
                end
            end else begin
                next_r.oc_cnt[i] = 20'h00000;
                trip = oc_analog_trip[i];
            end
            if (trip) begin
                next_r.oc_latch[i] = 1'b1;
            end
        end
        next_r.psw_n = ~(next_r.port_en & ~next_r.oc_latch);

        // Pin and block disables follow the state
        next_r.wake_oe = (next_r.st != pwr_pkg::PWR_SUSPEND);
        next_r.blk_dis = running ? next_r.pd_ctrl[15:0] : 16'hFFFF;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= pwr_pkg::PWR_WAKING;
            r.hw_cfg <= `HW_CFG_RESET;
            r.pd_ctrl <= `PD_CTRL_RESET;
            r.win_cnt <= 16'(`PD_CTRL_RESET >> `CLKOFF_LSB);
            r.port_en <= `PORT_PWR_RESET;
            r.psw_n <= 3'h0;
            r.wake_oe <= 1'b1;
            r.blk_dis <= 16'hFFFF;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops, except the wake pin drive value, which is tied to 0
    assign apb_out = r.rsp;
    assign suspend_wake_pin_out = 1'b0;
    assign suspend_wake_pin_oe = r.wake_oe;
    assign port_power_switch_n = r.psw_n;
    assign main_clk_out = r.clk_out;
    assign block_disable = r.blk_dis;
    assign clocks_ready_irq = r.irq;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wake;
        r.st == pwr_pkg::PWR_SUSPEND ##1 r.st == pwr_pkg::PWR_WAKING;
    endsequence

    AST_PIN_STATE: assert property ((r.st == pwr_pkg::PWR_SUSPEND) == !suspend_wake_pin_oe)
        else $error("wake pin drive does not match state");
    AST_PIN_WAKE: assert property (r.st == pwr_pkg::PWR_SUSPEND && !suspend_wake_pin_in
        |=> r.st == pwr_pkg::PWR_WAKING)
        else $error("low wake pin did not wake");
    AST_CS_WAKE: assert property (r.st == pwr_pkg::PWR_SUSPEND && apb_in.psel
        |=> r.st == pwr_pkg::PWR_WAKING)
        else $error("chip select did not wake");
    AST_CONN_WAKE: assert property (r.st == pwr_pkg::PWR_SUSPEND && port_connect != r.conn_prev
        |=> r.st == pwr_pkg::PWR_WAKING)
        else $error("attach change did not wake");
    AST_CLOCKS_STOP: assert property (r.st == pwr_pkg::PWR_SUSPEND [*2] |-> main_clk_out == 3'h0)
        else $error("main clocks run in suspend");
    AST_WINDOW_LOAD: assert property (s_wake |-> r.win_cnt == $past(r.pd_ctrl, 1) >> `CLKOFF_LSB)
        else $error("resume window not loaded");
    // Window exits: run/stop keeps it running, expiry suspends
    AST_RUN_HOLD: assert property (r.st == pwr_pkg::PWR_RESUME && r.run_stop
        |=> r.st == pwr_pkg::PWR_RUN ##1 (r.st == pwr_pkg::PWR_RUN || $past(sus_req)))
        else $error("run/stop did not keep device running");
    AST_WINDOW_EXPIRE: assert property (r.st == pwr_pkg::PWR_RESUME && !r.run_stop
        && r.win_cnt == 16'h0000 |=> r.st == pwr_pkg::PWR_SUSPEND)
        else $error("expired window did not suspend");
    AST_WINDOW_TICK: assert property (r.st == pwr_pkg::PWR_RESUME && !r.run_stop && slow_tick
        && r.win_cnt > 16'h0001 |=> r.win_cnt == $past(r.win_cnt) - 16'h0001)
        else $error("window did not count slow tick");
    // Port power protection
    AST_ANALOG_CUT: assert property (!r.hw_cfg[`OC_DIGITAL_BIT] && oc_analog_trip[0]
        |=> port_power_switch_n[0])
        else $error("analog overcurrent did not cut power");
    AST_LATCH_HOLD: assert property (r.oc_latch[1] && !(wr && a == `PORT_PWR_OFF)
        |=> port_power_switch_n[1])
        else $error("overcurrent latch released without a port power write");

    // Digital filter full on port 1 while its input is still low
    sequence s_oc_full;
        r.hw_cfg[`OC_DIGITAL_BIT] && !port_overcurrent_n[1] && r.oc_cnt[1] == 20'(OC_FILTER_CYCLES - 1);
    endsequence

    AST_DIGITAL_CUT: assert property (s_oc_full |=> port_power_switch_n[1])
        else $error("filtered overcurrent did not cut power");
    AST_FILTER_RESTART: assert property (r.hw_cfg[`OC_DIGITAL_BIT] && port_overcurrent_n[1]
        |=> r.oc_cnt[1] == 20'h00000)
        else $error("glitch filter not restarted by a high input");

    // Clock-ready flag and block disables
    AST_READY_SET: assert property (r.st == pwr_pkg::PWR_WAKING && r.lock_cnt == `LOCK_REF_EDGES
        |=> clocks_ready_irq && r.st == pwr_pkg::PWR_RESUME)
        else $error("clock-ready not raised at lock");
    AST_READY_CLEAR: assert property (r.st != pwr_pkg::PWR_WAKING && wr && a == `INTR_OFF
        && apb_in.pwdata[`CLK_READY_BIT] |=> !clocks_ready_irq)
        else $error("write of one did not clear clock-ready");
    AST_BLOCK_OFF: assert property (r.st == pwr_pkg::PWR_SUSPEND |-> block_disable == 16'hFFFF)
        else $error("internal blocks enabled in suspend");
endmodule

// file: rtl/pwr_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the power control block
// Assumes: pclk at 125 MHz, APB byte addresses taken from paddr[11:0]
// Notes: definitions only
`ifndef PWR_MAP_SVH
`define PWR_MAP_SVH

// Register byte offsets
`define HOST_CMD_OFF 12'h020
`define HW_CFG_OFF 12'h300
`define INTR_OFF 12'h310
`define PD_CTRL_OFF 12'h354
`define STATUS_OFF 12'h380
`define PORT_PWR_OFF 12'h384

// Field positions
`define RUN_STOP_BIT 0
`define SUSPEND_REQ_BIT 1
`define OC_DIGITAL_BIT 15
`define CLK_READY_BIT 0
`define CLKOFF_LSB 16

// Reset values
`define HW_CFG_RESET 32'h0000_0100
`define PD_CTRL_RESET 32'h03E8_1BA0
`define PORT_PWR_RESET 3'h7

// Frequencies in kHz
`define PCLK_KHZ 125000
`define REF_KHZ 12000
`define SLOW_KHZ 100
`define CLK30_KHZ 30000
`define CLK48_KHZ 48000
`define CLK60_KHZ 60000

// Phase increments of the 16-bit accumulators, rounded to nearest
// 64-bit product: the kHz figure times 65536 overflows a 32-bit int
`define PHASE_INC(f) (((f) * 64'd65536 + `PCLK_KHZ / 2) / `PCLK_KHZ)

// Slow clock divider in pclk cycles
`define SLOW_DIV (`PCLK_KHZ / `SLOW_KHZ)

// Reference supervision and lock
`define REF_GAP_MAX 6'h20
`define LOCK_REF_EDGES 7'h40

// Overcurrent timing
`define OC_FILTER_MS 5
`define OC_FILTER_CYCLES (`OC_FILTER_MS * (`PCLK_KHZ))
`define OC_LIMIT_MS 15

`endif

// file: rtl/pwr_pkg.sv
// Purpose: types shared by the power control block
// Assumes: nothing beyond pwr_map.svh
// Notes: registers state is one packed struct
package pwr_pkg;

    typedef enum logic [1:0] {PWR_SUSPEND, PWR_WAKING, PWR_RESUME, PWR_RUN} power_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    typedef struct packed {
        power_state_type st;
        logic run_stop;
        logic [31:0] hw_cfg;
        logic [31:0] pd_ctrl;
        logic ready_flag;
        logic [2:0] port_en;
        logic [2:0] oc_latch;
        logic [2:0] conn_prev;
        logic ref_prev;
        logic [5:0] ref_gap;
        logic [6:0] lock_cnt;
        logic [15:0] win_cnt;
        logic [2:0][15:0] acc;
        logic [2:0][19:0] oc_cnt;
        apb_rsp_type rsp;
        logic wake_oe;
        logic [2:0] clk_out;
        logic [2:0] psw_n;
        logic [15:0] blk_dis;
        logic irq;
    } pwr_regs_type;

endpackage

// file: rtl/slow_clock_gen.sv
// Purpose: free-running slow clock and its tick, kept alive in suspend
// Assumes: pclk never stops
// Notes: tick is one pclk cycle wide, once per slow period
`timescale 1ns/1ps
`include "pwr_map.svh"

module slow_clock_gen (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    output logic slow_tick, // One-cycle pulse per slow period
    output logic slow_clk // Slow square wave
);
    logic [10:0] cnt;

    // Divide pclk down to the slow rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 11'h000;
            slow_tick <= 1'b0;
            slow_clk <= 1'b0;
        end else begin
            slow_tick <= (cnt == 11'(`SLOW_DIV - 1));
            if (cnt == 11'(`SLOW_DIV - 1)) begin
                cnt <= 11'h000;
            end else begin
                cnt <= cnt + 11'h001;
            end
            slow_clk <= (cnt >= 11'(`SLOW_DIV / 2));
        end
    end
endmodule

// file: tb/host_side_model.sv
// Purpose: host GPIO with pull-up, 12 MHz reference and external port power switches
// Assumes: pclk at 125 MHz; bench commands the GPIO and the load faults
// Notes: switch reports a fault only while its port is powered
`timescale 1ns/1ps

module host_side_model (
    input wire logic pclk, // System clock
    input wire logic gpio_low, // Host GPIO drives the pin low
    input wire logic pin_oe, // Device drive enable
    input wire logic pin_out, // Device drive value
    input wire logic [2:0] oc_req, // Load fault per port
    input wire logic [2:0] psw_n, // Switch control, active low
    output logic pin_level, // Resolved wake pin
    output logic ref_clk = 1'b0, // 12 MHz reference
    output logic [2:0] oc_n = 3'h7 // Switch fault flags, active low
);
    logic [15:0] phase = 16'h0000;

    // Pull-up holds the pin high unless a party drives it low
    assign pin_level = pin_oe ? pin_out : !gpio_low;

    // Reference from a phase accumulator, switch faults follow power
    always @(posedge pclk) begin
        phase <= phase + 16'h1893;
        ref_clk <= phase[15];
        oc_n <= ~(oc_req & ~psw_n);
    end
endmodule

// file: tb/test_suspend_wake_power_control.sv
// Purpose: self-checking bench of the suspend, wake and port power block
// Assumes: APB zero wait states; filter shortened to 20 cycles
// Notes: no APB access while suspended unless a wake by select is meant
`timescale 1ns/1ps
`include "pwr_map.svh"

module test_suspend_wake_power_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    pwr_pkg::apb_req_type apb_in = '0;
    pwr_pkg::apb_rsp_type apb_out;
    logic [2:0] port_connect = 3'h0;
    logic [2:0] oc_analog_trip = 3'h0;
    logic [2:0] oc_req = 3'h0;
    logic gpio_low = 1'b0;
    logic ref_clk, pin_level, pin_out, pin_oe, slow_clk, irq, err;
    logic [2:0] oc_n, psw_n, mclk, prev;
    logic [15:0] blk;
    logic [31:0] rd;
    int err_count = 0;
    int total_checks = 0;
    int c;
    int lock_wait;

    // Clock generator
    initial forever #4 pclk = ~pclk;

    suspend_wake_power_control #(.OC_FILTER_CYCLES(20)) suspend_wake_power_control_inst (
        .pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out), .ref_clock_input(ref_clk),
        .port_connect(port_connect), .suspend_wake_pin_in(pin_level), .suspend_wake_pin_out(pin_out),
        .suspend_wake_pin_oe(pin_oe), .port_overcurrent_n(oc_n), .oc_analog_trip(oc_analog_trip),
        .port_power_switch_n(psw_n), .main_clk_out(mclk), .slow_free_clock(slow_clk),
        .block_disable(blk), .clocks_ready_irq(irq));

    host_side_model host_side_model_inst (
        .pclk(pclk), .gpio_low(gpio_low), .pin_oe(pin_oe), .pin_out(pin_out), .oc_req(oc_req),
        .psw_n(psw_n), .pin_level(pin_level), .ref_clk(ref_clk), .oc_n(oc_n));

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic timeout(input string name);
        err_count++;
        $display("MISMATCH %s expected done seen timeout", name);
        finish_test();
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        apb_in <= '{1'b1, 1'b0, wr, {20'h0, addr}, wd};
        @(posedge pclk);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_out.pready !== 1'b1 && k < 20);
        if (k >= 20) timeout("pready");
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in <= '0;
    endtask

    function automatic logic pick(input int w);
        return w == 0 ? pin_oe : (w == 1 ? irq : psw_n[1]);
    endfunction

    // Bounded wait: 0 pin enable, 1 clock-ready, 2 port 1 switch
    task automatic wait_for(input int w, input logic v, input int lim, output int n);
        n = 0;
        while (pick(w) !== v) begin
            @(posedge pclk);
            n++;
            if (n > lim) timeout("wait");
        end
    endtask

    task automatic t_reset();
        apb(1'b0, `HW_CFG_OFF, 32'h0);
        chk("hw_cfg", `HW_CFG_RESET, rd);
        apb(1'b0, `PD_CTRL_OFF, 32'h0);
        chk("pd_ctrl", 32'h03E8_1BA0, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        chk("psw", 3'h0, psw_n);
    endtask

    // First lock, clock rates, flag clear, run and block disables
    task automatic t_first_wake();
        wait_for(1, 1'b1, 12500, c);
        chk("oe", 1'b1, pin_oe);
        for (int b = 0; b < 3; b++) begin
            c = 0;
            prev = mclk;
            repeat (125) begin
                @(posedge pclk);
                if (mclk[b] && !prev[b]) c++;
                prev = mclk;
            end
            chk("rate", 1'b1, c >= (b == 0 ? 29 : b == 1 ? 47 : 59) && c <= (b == 0 ? 31 : b == 1 ? 49 : 61));
        end
        apb(1'b0, `STATUS_OFF, 32'h0);
        chk("state", 2'h2, rd[1:0]);
        apb(1'b1, `INTR_OFF, 32'h1);
        apb(1'b1, `HOST_CMD_OFF, 32'h1);
        chk("irq", 1'b0, irq);
        apb(1'b1, `PD_CTRL_OFF, 32'h0003_1BA0);
        apb(1'b0, `STATUS_OFF, 32'h0);
        chk("state", 2'h3, rd[1:0]);
        chk("blk", 16'h1BA0, blk);
    endtask

    // Suspend request: clocks stop, slow clock runs, pin released and high
    task automatic t_suspend();
        apb(1'b1, `HOST_CMD_OFF, 32'h2);
        repeat (3) @(posedge pclk);
        chk("oe", 1'b0, pin_oe);
        chk("pin", 1'b1, pin_level);
        chk("blk", 16'hFFFF, blk);
        c = 0;
        prev = 3'h0;
        repeat (2600) begin
            @(posedge pclk);
            if (slow_clk && !prev[0]) c++;
            if (mclk !== 3'h0 || pin_oe !== 1'b0) prev[2] = 1'b1;
            prev[0] = slow_clk;
        end
        chk("slow", 1'b1, c >= 2);
        chk("stopped", 1'b0, prev[2]);
    endtask

    // GPIO wake, flag raised and cleared in resume, window of 3 slow ticks runs out
    task automatic t_window();
        gpio_low <= 1'b1;
        wait_for(0, 1'b1, 4, c);
        gpio_low <= 1'b0;
        wait_for(1, 1'b1, 12500, lock_wait);
        apb(1'b1, `INTR_OFF, 32'h1);
        @(posedge pclk);
        chk("irq", 1'b0, irq);
        wait_for(0, 1'b0, 3 * 1250 + 60, c);
        chk("window", 1'b1, lock_wait + 4 + c >= 2 * 1250);
        chk("irq", 1'b0, irq);
    endtask

    // Attach wakes; run/stop inside the window keeps it running
    task automatic t_connect();
        port_connect <= 3'h1;
        wait_for(0, 1'b1, 4, c);
        wait_for(1, 1'b1, 12500, c);
        apb(1'b1, `INTR_OFF, 32'h1);
        apb(1'b1, `HOST_CMD_OFF, 32'h1);
        repeat (5000) @(posedge pclk);
        chk("oe", 1'b1, pin_oe);
        apb(1'b1, `HOST_CMD_OFF, 32'h2);
        wait_for(0, 1'b0, 4, c);
        apb(1'b0, `STATUS_OFF, 32'h0);
        chk("oe", 1'b1, pin_oe);
        wait_for(1, 1'b1, 12500, c);
        apb(1'b1, `HOST_CMD_OFF, 32'h1);
    endtask

    // Analog trip, then digital filter with a short glitch
    task automatic t_oc();
        oc_analog_trip <= 3'h1;
        repeat (3) @(posedge pclk);
        oc_analog_trip <= 3'h0;
        chk("psw", 3'h1, psw_n);
        apb(1'b1, `PORT_PWR_OFF, 32'h7);
        repeat (2) @(posedge pclk);
        chk("psw", 3'h0, psw_n);
        apb(1'b1, `HW_CFG_OFF, 32'h0000_8100);
        oc_req <= 3'h2;
        repeat (10) @(posedge pclk);
        oc_req <= 3'h0;
        repeat (30) @(posedge pclk);
        chk("glitch", 3'h0, psw_n);
        oc_req <= 3'h2;
        wait_for(2, 1'b1, 25, c);
        chk("filter", 1'b1, c >= 20);
        chk("psw", 3'h2, psw_n);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_first_wake();
        t_suspend();
        t_window();
        t_connect();
        t_oc();
        finish_test();
    end
endmodule
